// ### design/bop_color_expand.sv
// One colour expansion lane: keeps the low bytes that the colour depth uses.
// Assumes depth and colour come from logic on the same clock.
`timescale 1ns/1ps
module bop_color_expand #(
    parameter int CW = 32
) (
    // Clock and control
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  clk_en,
    // Colour lane
    bop_color_if.lane  cl
);

    if (CW != 32) begin : g_bad_cw
        $error("bop_color_expand supports 32-bit colours only");
    end

    // Registered selection of one, two or four colour bytes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cl.expd <= '0;
        end else if (clk_en) begin
            case (cl.depth)
                bop_pkg::BOP_DEPTH_8:  cl.expd <= {24'h00_0000, cl.raw[7:0]};
                bop_pkg::BOP_DEPTH_16: cl.expd <= {16'h0000, cl.raw[15:0]};
                bop_pkg::BOP_DEPTH_24: cl.expd <= cl.raw;
                default:               cl.expd <= cl.raw; // Reserved code keeps all bytes
            endcase
        end
    end

endmodule

// ### design/bop_color_if.sv
// Carrier between the bank and one colour expansion lane.
// Assumes one bank driver and one expander per instance.
`timescale 1ns/1ps
interface bop_color_if #(parameter int CW = 32);
    logic [CW-1:0]     raw;
    bop_pkg::bop_depth_e depth;
    logic [CW-1:0]     expd;

    // Bank side drives colour and depth
    modport bank (output raw, output depth, input expd);
    // Expander side answers with the selected colour
    modport lane (input raw, input depth, output expd);
endinterface

// ### design/bop_operand_bank.sv
// Blit operand parameter bank: extent, pattern base, expansion colours,
// request unit control and blitter streamer address relay.
// Assumes the command streamer, MMIO master and translation logic share mclk.
`timescale 1ns/1ps
`include "bop_regs.svh"
module bop_operand_bank #(
    parameter int CW  = 32,
    parameter int EXW = 13
) (
    // Clock, reset, enable
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    // Memory-mapped register port
    input  wire logic         mm_req,
    input  wire logic         mm_wr,
    input  wire logic [31:0]  mm_addr,
    input  wire logic [31:0]  mm_wdata,
    output logic              mm_ack,
    output logic [31:0]       mm_rdata,
    output logic              mm_unmapped,
    // Streamer window relay
    output logic              cs_fwd_valid,
    output logic              cs_fwd_wr,
    output logic [31:0]       cs_fwd_addr,
    output logic [31:0]       cs_fwd_wdata,
    // Command streamer loads of working registers
    input  wire logic         ld_valid,
    input  wire logic [2:0]   ld_sel,
    input  wire logic [31:0]  ld_data,
    input  wire logic [1:0]   cfg_depth,
    input  wire logic         line_done,
    // Extent and pattern views
    output logic [EXW-1:0]    dst_height,
    output logic [EXW-1:0]    dst_width_bytes,
    output logic [EXW-1:0]    dst_width_pixels,
    output logic              extent_active,
    output logic [28:0]       pat_addr,
    output logic [15:0]       pat_bytes,
    output logic [63:0]       mono_pattern,
    output logic              depth_reserved,
    // Expanded colours
    output logic [CW-1:0]     pat_bg_color,
    output logic [CW-1:0]     pat_fg_color,
    output logic [CW-1:0]     src_bg_color,
    output logic [CW-1:0]     src_fg_color,
    output logic [CW-1:0]     dst_key_color,
    output logic [CW-1:0]     fill_color,
    // Translation requests of the request unit
    input  wire logic         tr_valid,
    input  wire logic [38:0]  tr_addr,
    input  wire logic         tr_fault,
    output logic              tr_out_valid,
    output logic [39:0]       tr_out_addr,
    output logic              tr_ready,
    output logic              ru_stalled,
    // Arbiter and translation buffer controls
    output logic [1:0]        arb_wr_pri,
    output logic [1:0]        arb_ro_pri,
    output logic [1:0]        arb_rd_pri,
    output logic [1:0]        tlb_partition
);

    if (CW != 32) begin : g_bad_cw
        $error("bop_operand_bank supports 32-bit colours only");
    end
    if (EXW != `BOP_EXT_BITS) begin : g_bad_exw
        $error("bop_operand_bank extent fields are 13 bits wide");
    end

    localparam logic [31:0] RUC_RST  = `BOP_RUC_RESET;
    localparam logic [31:0] FWD_DISP = `BOP_BCS_BASE - `BOP_PRI_BASE;

    // Stored state
    logic [EXW-1:0]               height_r;
    logic [EXW-1:0]               width_r;
    logic [22:0]                  patbase_r;
    logic [CW-1:0]                pat_bg_r;
    logic [CW-1:0]                pat_fg_r;
    logic [CW-1:0]                src_bg_r;
    logic [CW-1:0]                src_fg_r;
    logic [63:0]                  mono_r;
    logic [`BOP_RUC_KEEP-1:0]     ruc_r;
    bop_pkg::bop_ru_e             ru_state_r;
    bop_pkg::bop_depth_e          depth_w;
    logic [1:0]                   depth_shift;
    logic                         ld_hit;
    logic                         hit_ruc;
    logic                         hit_pbg;
    logic                         hit_bcs;
    logic [31:0]                  rd_nxt;
    logic [31:0]                  ruc_view;

    // Depth code decode: bytes-per-pixel shift
    assign depth_w = bop_pkg::bop_depth_e'(cfg_depth);
    always_comb begin
        case (depth_w)
            bop_pkg::BOP_DEPTH_8:  depth_shift = 2'd0;
            bop_pkg::BOP_DEPTH_16: depth_shift = 2'd1;
            bop_pkg::BOP_DEPTH_24: depth_shift = 2'd2;
            default:               depth_shift = 2'd2;
        endcase
    end

    assign ld_hit = ld_valid && clk_en;

    // Extent load; height counts down per scan line
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            height_r <= '0;
            width_r  <= '0;
        end else if (ld_hit && ld_sel == bop_pkg::BOP_LD_EXTENT) begin
            height_r <= ld_data[`BOP_EXT_H_MSB:`BOP_EXT_H_LSB];
            width_r  <= ld_data[`BOP_EXT_W_MSB:0];
        end else if (clk_en && line_done && height_r != '0) begin
            height_r <= height_r - 1'b1;
        end
    end

    // Pattern base keeps only address bits 28:6
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            patbase_r <= '0;
        end else if (ld_hit && ld_sel == bop_pkg::BOP_LD_PATBASE) begin
            patbase_r <= ld_data[`BOP_PAT_MSB:`BOP_PAT_LSB];
        end
    end

    // Expansion colours loaded by the streamer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pat_bg_r <= '0;
            pat_fg_r <= '0;
            src_bg_r <= '0;
            src_fg_r <= '0;
        end else if (ld_hit) begin
            case (bop_pkg::bop_ld_e'(ld_sel))
                bop_pkg::BOP_LD_PAT_BG: pat_bg_r <= ld_data;
                bop_pkg::BOP_LD_PAT_FG: pat_fg_r <= ld_data;
                bop_pkg::BOP_LD_SRC_BG: src_bg_r <= ld_data;
                bop_pkg::BOP_LD_SRC_FG: src_fg_r <= ld_data;
                default: ;
            endcase
        end
    end

    // Mono pattern from the command, low word first
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mono_r <= '0;
        end else if (ld_hit && ld_sel == bop_pkg::BOP_LD_MONO_LO) begin
            mono_r[31:0] <= ld_data;
        end else if (ld_hit && ld_sel == bop_pkg::BOP_LD_MONO_HI) begin
            mono_r[63:32] <= ld_data;
        end
    end

    // Derived extent and pattern views
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dst_height       <= '0;
            dst_width_bytes  <= '0;
            dst_width_pixels <= '0;
            extent_active    <= 1'b0;
            pat_addr         <= '0;
            pat_bytes        <= '0;
            mono_pattern     <= '0;
            depth_reserved   <= 1'b0;
        end else if (clk_en) begin
            dst_height       <= height_r;
            dst_width_bytes  <= width_r;
            dst_width_pixels <= width_r >> depth_shift;
            extent_active    <= (height_r != '0) && (width_r != '0);
            pat_addr         <= {patbase_r, 6'h00};
            pat_bytes        <= 16'(`BOP_PAT_BYTES_8BPP << depth_shift);
            mono_pattern     <= mono_r;
            depth_reserved   <= (depth_w == bop_pkg::BOP_DEPTH_RSV);
        end
    end

    // Four colour expansion lanes
    bop_color_if #(.CW(CW)) cif[4] ();
    assign cif[0].raw = pat_bg_r;
    assign cif[1].raw = pat_fg_r;
    assign cif[2].raw = src_bg_r;
    assign cif[3].raw = src_fg_r;

    for (genvar gi = 0; gi < 4; gi++) begin : g_lane
        assign cif[gi].depth = depth_w;
        bop_color_expand #(.CW(CW)) u_exp (
            .mclk    (mclk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .cl      (cif[gi])
        );
    end

    assign pat_bg_color  = cif[0].expd;
    assign pat_fg_color  = cif[1].expd;
    assign src_bg_color  = cif[2].expd;
    assign src_fg_color  = cif[3].expd;

    // Transparency key and solid fill share the source background colour
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dst_key_color <= '0;
            fill_color    <= '0;
        end else if (clk_en) begin
            dst_key_color <= cif[2].expd;
            fill_color    <= cif[2].expd;
        end
    end

    // Address decode of the memory-mapped port
    assign hit_ruc = (mm_addr == `BOP_RUC_OFS);
    assign hit_pbg = (mm_addr == `BOP_PBG_OFS);
    assign hit_bcs = (mm_addr >= `BOP_BCS_BASE) &&
                     (mm_addr < (`BOP_BCS_BASE + `BOP_BCS_SPAN));

    // Control view: only the nine live bits, the rest read zero
    assign ruc_view = {23'h00_0000, ruc_r};

    // Request unit control register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ruc_r <= RUC_RST[`BOP_RUC_KEEP-1:0];
        end else if (clk_en && mm_req && mm_wr && hit_ruc) begin
            ruc_r <= mm_wdata[`BOP_RUC_KEEP-1:0];
        end
    end

    // Arbiter and buffer controls from the control flops
    assign arb_wr_pri    = ruc_r[`BOP_RUC_WRP_LSB+:2];
    assign arb_ro_pri    = ruc_r[`BOP_RUC_ROP_LSB+:2];
    assign arb_rd_pri    = ruc_r[`BOP_RUC_RDP_LSB+:2];
    assign tlb_partition = ruc_r[`BOP_RUC_TLB_LSB+:2];

    // Read data select; writes to the background colour are ignored
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_ruc) begin
            rd_nxt = ruc_view;
        end else if (hit_pbg) begin
            rd_nxt = pat_bg_r;
        end
    end

    // One-cycle answer to every request made while clk_en is high
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mm_ack      <= 1'b0;
            mm_rdata    <= '0;
            mm_unmapped <= 1'b0;
        end else if (clk_en) begin
            mm_ack      <= mm_req;
            mm_rdata    <= (mm_req && !mm_wr) ? rd_nxt : 32'h0000_0000;
            mm_unmapped <= mm_req && !(hit_ruc || hit_pbg || hit_bcs);
        end
    end

    // Streamer window relay at the primary displacement
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cs_fwd_valid <= 1'b0;
            cs_fwd_wr    <= 1'b0;
            cs_fwd_addr  <= '0;
            cs_fwd_wdata <= '0;
        end else if (clk_en) begin
            cs_fwd_valid <= mm_req && hit_bcs;
            if (mm_req && hit_bcs) begin
                cs_fwd_wr    <= mm_wr;
                cs_fwd_addr  <= mm_addr - FWD_DISP;
                cs_fwd_wdata <= mm_wdata;
            end
        end
    end

    // Fault policy: continue with bit 39 marked, or stall until reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ru_state_r <= bop_pkg::BOP_RU_RUN;
        end else if (clk_en) begin
            case (ru_state_r)
                bop_pkg::BOP_RU_RUN: begin
                    if (tr_valid && tr_fault && !ruc_r[`BOP_RUC_CPF_BIT]) begin
                        ru_state_r <= bop_pkg::BOP_RU_STALL;
                    end
                end
                bop_pkg::BOP_RU_STALL: ru_state_r <= bop_pkg::BOP_RU_STALL;
                default:               ru_state_r <= bop_pkg::BOP_RU_RUN;
            endcase
        end
    end

    // Translated request output
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tr_out_valid <= 1'b0;
            tr_out_addr  <= '0;
            tr_ready     <= 1'b0;
            ru_stalled   <= 1'b0;
        end else if (clk_en) begin
            tr_ready   <= (ru_state_r == bop_pkg::BOP_RU_RUN) &&
                          !(tr_valid && tr_fault && !ruc_r[`BOP_RUC_CPF_BIT]);
            ru_stalled <= (ru_state_r == bop_pkg::BOP_RU_STALL) ||
                          (tr_valid && tr_fault && !ruc_r[`BOP_RUC_CPF_BIT]);
            tr_out_valid <= 1'b0;
            if (ru_state_r == bop_pkg::BOP_RU_RUN && tr_valid) begin
                if (!tr_fault) begin
                    tr_out_valid <= 1'b1;
                    tr_out_addr  <= {1'b0, tr_addr};
                end else if (ruc_r[`BOP_RUC_CPF_BIT]) begin
                    tr_out_valid <= 1'b1;
                    tr_out_addr  <= {1'b1, tr_addr};
                end
            end
        end
    end

endmodule

// ### design/bop_pkg.sv
// Types shared by the blit operand parameter bank.
// Assumes the constants header sits beside it.
package bop_pkg;

    // Colour depth code
    typedef enum logic [1:0] {
        BOP_DEPTH_8   = 2'b00,
        BOP_DEPTH_16  = 2'b01,
        BOP_DEPTH_24  = 2'b10,
        BOP_DEPTH_RSV = 2'b11
    } bop_depth_e;

    // Working register chosen by the command streamer load port
    typedef enum logic [2:0] {
        BOP_LD_EXTENT  = 3'h0,
        BOP_LD_PATBASE = 3'h1,
        BOP_LD_PAT_BG  = 3'h2,
        BOP_LD_PAT_FG  = 3'h3,
        BOP_LD_SRC_BG  = 3'h4,
        BOP_LD_SRC_FG  = 3'h5,
        BOP_LD_MONO_LO = 3'h6,
        BOP_LD_MONO_HI = 3'h7
    } bop_ld_e;

    // Request unit fault state
    typedef enum logic [1:0] {
        BOP_RU_RUN   = 2'b00,
        BOP_RU_STALL = 2'b01
    } bop_ru_e;

endpackage

// ### design/bop_regs.svh
// Offsets, field positions, reset values and encodings of the blit operand bank.
// Assumes inclusion by bare name from the top module.
`ifndef BOP_REGS_SVH
`define BOP_REGS_SVH

// Memory-mapped offsets
`define BOP_RUC_OFS        32'h0002_4000
`define BOP_PBG_OFS        32'h0004_0040
`define BOP_BCS_BASE       32'h0002_0000
`define BOP_PRI_BASE       32'h0000_2000
`define BOP_BCS_SPAN       32'h0000_4000

// Request unit control layout
`define BOP_RUC_RESET      32'hFF00_00BF
`define BOP_RUC_KEEP       9
`define BOP_RUC_CPF_BIT    8
`define BOP_RUC_TLB_LSB    6
`define BOP_RUC_WRP_LSB    4
`define BOP_RUC_ROP_LSB    2
`define BOP_RUC_RDP_LSB    0

// Destination extent layout
`define BOP_EXT_H_LSB      16
`define BOP_EXT_H_MSB      28
`define BOP_EXT_W_MSB      12
`define BOP_EXT_BITS       13

// Pattern base layout
`define BOP_PAT_MSB        28
`define BOP_PAT_LSB        6
`define BOP_ADDR_BITS      29

// Pattern geometry
`define BOP_PAT_BYTES_8BPP 16'h0040
`define BOP_MONO_BYTES     8

// Translation fault marker position
`define BOP_FAULT_BIT      39

`endif

// ### dv/bop_operand_bank_asserts.sv
// Concurrent checks on the ports of the blit operand bank.
// Assumes one clock mclk and a synchronous active-high sys_rst.
`timescale 1ns/1ps
module bop_operand_bank_asserts #(
    parameter int CW = 32
) (
    // Clock and reset
    input wire logic          mclk,
    input wire logic          sys_rst,
    input wire logic          clk_en,
    // Register port
    input wire logic          mm_req,
    input wire logic          mm_wr,
    input wire logic [31:0]   mm_addr,
    input wire logic [31:0]   mm_wdata,
    input wire logic          mm_ack,
    input wire logic [31:0]   mm_rdata,
    input wire logic          mm_unmapped,
    input wire logic          cs_fwd_valid,
    input wire logic [31:0]   cs_fwd_addr,
    // Views and colours
    input wire logic [1:0]    cfg_depth,
    input wire logic [28:0]   pat_addr,
    input wire logic [15:0]   pat_bytes,
    input wire logic [CW-1:0] pat_bg_color,
    input wire logic [CW-1:0] pat_fg_color,
    input wire logic [CW-1:0] src_bg_color,
    input wire logic [CW-1:0] src_fg_color,
    input wire logic [CW-1:0] dst_key_color,
    input wire logic [CW-1:0] fill_color,
    // Translation and arbiter controls
    input wire logic          tr_valid,
    input wire logic [38:0]   tr_addr,
    input wire logic          tr_fault,
    input wire logic          tr_ready,
    input wire logic          tr_out_valid,
    input wire logic [39:0]   tr_out_addr,
    input wire logic          ru_stalled,
    input wire logic [1:0]    arb_wr_pri,
    input wire logic [1:0]    arb_ro_pri,
    input wire logic [1:0]    arb_rd_pri,
    input wire logic [1:0]    tlb_partition
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic cpf_r;
    // Mirror of the continue-after-fault bit
    always_ff @(posedge mclk) begin
        if (sys_rst)
            cpf_r <= 1'b0;
        else if (clk_en && mm_req && mm_wr && mm_addr == 32'h0002_4000)
            cpf_r <= mm_wdata[8];
    end

    // Accepted register access and accepted translation fault
    sequence s_take;
        clk_en && mm_req;
    endsequence
    sequence s_fault;
        clk_en && tr_valid && tr_ready && tr_fault;
    endsequence

    // Register port answers
    a_ctl_reserved: assert property (s_take ##0 (!mm_wr && mm_addr == 32'h0002_4000) |=> mm_rdata[31:9] == 23'h0)
        else $error("control reserved bits read nonzero");
    a_relay_offset: assert property (s_take ##0 ((mm_addr >> 14) == 32'h8)
        |=> cs_fwd_valid && cs_fwd_addr == $past(mm_addr) - 32'h0001_E000)
        else $error("streamer relay address wrong");
    a_unmapped_flag: assert property (s_take |=> mm_ack && mm_unmapped == !($past(mm_addr) == 32'h0002_4000
        || $past(mm_addr) == 32'h0004_0040 || ($past(mm_addr) >> 14) == 32'h8))
        else $error("ack or unmapped flag wrong");
    // Translation fault policy
    a_fault_cont: assert property (s_fault ##0 cpf_r |=> tr_out_valid && tr_out_addr == {1'b1, $past(tr_addr)})
        else $error("fault not marked on bit 39");
    a_fault_stall: assert property (s_fault ##0 !cpf_r |=> ru_stalled && !tr_ready && !tr_out_valid)
        else $error("fault did not stall");
    a_stall_holds: assert property (ru_stalled |=> ru_stalled && !tr_ready && !tr_out_valid)
        else $error("stall released before reset");
    a_clean_xlate: assert property (clk_en && tr_valid && tr_ready && !tr_fault
        |=> tr_out_valid && tr_out_addr == {1'b0, $past(tr_addr)})
        else $error("clean translation not passed");
    // Pattern and colour views
    a_pat_low_zero: assert property (pat_addr[5:0] == 6'h00)
        else $error("pattern base low bits nonzero");
    a_pat_size: assert property ($stable(cfg_depth)[*4]
        |-> pat_bytes == (16'h0040 << (cfg_depth[1] ? 2 : cfg_depth[0])))
        else $error("pattern size wrong");
    a_color_mask: assert property ($stable(cfg_depth)[*4]
        |-> ((pat_bg_color | pat_fg_color | src_bg_color | src_fg_color)
        >> (cfg_depth[1] ? 32 : cfg_depth[0] ? 16 : 8)) == 0)
        else $error("colour not masked to depth");
    a_key_fill: assert property ($past(clk_en) |-> dst_key_color == $past(src_bg_color)
        && fill_color == $past(src_bg_color))
        else $error("key or fill colour stale");
    a_pri_reset: assert property ($fell(sys_rst) |-> arb_wr_pri == 2'b11 && arb_ro_pri == 2'b11
        && arb_rd_pri == 2'b11 && tlb_partition == 2'b10)
        else $error("control outputs not at reset values");
endmodule

bind bop_operand_bank bop_operand_bank_asserts #(.CW(CW)) chk_u (.*);

// ### dv/bop_streamer_model.sv
// Model of the blitter command streamer and translation source.
// Assumes the caller runs one task at a time on mclk.
`timescale 1ns/1ps
module bop_streamer_model (
    // Clock
    input  wire logic  mclk,
    // Working register loads
    output logic        ld_valid,
    output logic [2:0]  ld_sel,
    output logic [31:0] ld_data,
    output logic        line_done,
    // Translation results
    output logic        tr_valid,
    output logic [38:0] tr_addr,
    output logic        tr_fault
);
    // Idle levels
    initial begin
        {ld_valid, ld_sel, ld_data, line_done, tr_valid, tr_addr, tr_fault} = '0;
    end

    // One load beat; released data shows its inverse
    task automatic load(input logic [2:0] s, input logic [31:0] d);
        @(posedge mclk);
        ld_valid <= 1'b1;
        ld_sel <= s;
        ld_data <= d;
        @(posedge mclk);
        ld_valid <= 1'b0;
        ld_data <= ~d;
    endtask

    // Pattern base aligned to the pattern size
    task automatic pat_base(input logic [1:0] dep, input logic [28:0] a);
        logic [28:0] m;
        m = ~((29'h40 << (dep[1] ? 2 : dep[0])) - 29'h1);
        load(3'h1, {3'b000, a & m});
    endtask

    // One finished scan line, no more than the programmed height
    task automatic line();
        @(posedge mclk);
        line_done <= 1'b1;
        @(posedge mclk);
        line_done <= 1'b0;
    endtask

    // One translation result
    task automatic xlate(input logic [38:0] a, input logic f);
        @(posedge mclk);
        tr_valid <= 1'b1;
        tr_addr <= a;
        tr_fault <= f;
        @(posedge mclk);
        tr_valid <= 1'b0;
        tr_addr <= ~a;
    endtask
endmodule

// ### dv/test_blit_operand_parameter_regs.sv
// Self-checking bench of the blit operand bank.
// Assumes the streamer model drives the load and translation ports.
`timescale 1ns/1ps
module test_blit_operand_parameter_regs;
    typedef struct packed {
        logic [1:0]  dep;
        logic [2:0]  sel;
        logic [31:0] d;
        logic [31:0] e;
    } bop_row_s;

    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        mm_req = 1'b0;
    logic        mm_wr = 1'b0;
    logic [31:0] mm_addr = 32'h0;
    logic [31:0] mm_wdata = 32'h0;
    logic [1:0]  cfg_depth = 2'b00;
    logic        mm_ack, mm_unmapped, cs_fwd_valid, cs_fwd_wr, extent_active, depth_reserved;
    logic        ld_valid, line_done, tr_valid, tr_fault, tr_out_valid, tr_ready, ru_stalled;
    logic [2:0]  ld_sel;
    logic [31:0] mm_rdata, cs_fwd_addr, cs_fwd_wdata, ld_data, rd;
    logic [31:0] pat_bg_color, pat_fg_color, src_bg_color, src_fg_color, dst_key_color, fill_color;
    logic [12:0] dst_height, dst_width_bytes, dst_width_pixels;
    logic [28:0] pat_addr;
    logic [15:0] pat_bytes;
    logic [63:0] mono_pattern;
    logic [38:0] tr_addr;
    logic [39:0] tr_out_addr;
    logic [1:0]  arb_wr_pri, arb_ro_pri, arb_rd_pri, tlb_partition;
    logic [1:0]  un;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          sh;
    bop_row_s    rows [0:9] = '{
        '{2'b00, 3'h0, 32'hFFFF_FFFF, 32'h1FFF_1FFF}, '{2'b00, 3'h1, 32'hFFFF_FFFF, 32'h1FFF_FFC0},
        '{2'b00, 3'h2, 32'h1234_5678, 32'h0000_0078}, '{2'b01, 3'h3, 32'h1234_5678, 32'h0000_5678},
        '{2'b10, 3'h4, 32'h1234_5678, 32'h1234_5678}, '{2'b00, 3'h5, 32'h89AB_CDEF, 32'h0000_00EF},
        '{2'b01, 3'h4, 32'h89AB_CDEF, 32'h0000_CDEF}, '{2'b10, 3'h2, 32'h89AB_CDEF, 32'h89AB_CDEF},
        '{2'b00, 3'h6, 32'h0F1E_2D3C, 32'h0F1E_2D3C}, '{2'b00, 3'h7, 32'h4B5A_6978, 32'h4B5A_6978}};

    // Clock of 50 ns
    always #25 mclk = ~mclk;

    bop_operand_bank dut_u (.*);

    bop_streamer_model pm_u (.*);

    // Compare and count
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access; answer sampled just after the taking edge
    task automatic mm(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        mm_req <= 1'b1;
        mm_wr <= w;
        mm_addr <= a;
        mm_wdata <= d;
        @(posedge mclk);
        mm_req <= 1'b0;
        mm_wdata <= ~d;
        #1;
        rd = mm_rdata;
        un = {mm_ack, mm_unmapped};
    endtask

    // View chosen by a load select
    function automatic logic [31:0] view(input logic [2:0] s);
        case (s)
            3'h0: view = {3'b000, dst_height, 3'b000, dst_width_bytes};
            3'h1: view = {3'b000, pat_addr};
            3'h2: view = pat_bg_color;
            3'h3: view = pat_fg_color;
            3'h4: view = src_bg_color;
            3'h5: view = src_fg_color;
            3'h6: view = mono_pattern[31:0];
            default: view = mono_pattern[63:32];
        endcase
    endfunction

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        mm(1'b0, 32'h0002_4000, 32'h0);
        chk(rd, 32'h0000_00BF);
        chk({arb_wr_pri, arb_ro_pri, arb_rd_pri, tlb_partition}, 8'hFE);
        mm(1'b1, 32'h0002_4000, 32'hFFFF_FF2D);
        mm(1'b0, 32'h0002_4000, 32'h0);
        chk(rd, 32'h0000_012D);
        chk({arb_wr_pri, arb_ro_pri, arb_rd_pri, tlb_partition}, 8'b10_11_01_00);
        @(posedge mclk);
        clk_en <= 1'b0;
        mm(1'b1, 32'h0002_4000, 32'h0000_0000);
        chk({un, arb_wr_pri, arb_ro_pri, arb_rd_pri, tlb_partition}, 10'b00_10_11_01_00);
        @(posedge mclk);
        clk_en <= 1'b1;
        $display("test control done");
        foreach (rows[i]) begin
            @(posedge mclk);
            cfg_depth <= rows[i].dep;
            pm_u.load(rows[i].sel, rows[i].d);
            @(posedge mclk);
            #1;
            chk(view(rows[i].sel), rows[i].e);
        end
        $display("test loads done");
        mm(1'b1, 32'h0004_0040, 32'h0);
        mm(1'b0, 32'h0004_0040, 32'h0);
        chk({un, rd}, {2'b10, 32'h89AB_CDEF});
        mm(1'b0, 32'h0000_1000, 32'h0);
        chk({un, rd}, {2'b11, 32'h0});
        mm(1'b1, 32'h0002_1234, 32'hCAFE_0001);
        chk({cs_fwd_valid, cs_fwd_wr, cs_fwd_addr, cs_fwd_wdata}, {2'b11, 32'h0000_3234, 32'hCAFE_0001});
        $display("test decode done");
        @(posedge mclk);
        cfg_depth <= 2'b10;
        pm_u.load(3'h4, 32'h5A5A_A5A5);
        repeat (2) @(posedge mclk);
        #1;
        chk({dst_key_color, fill_color}, {2{32'h5A5A_A5A5}});
        for (int d = 0; d < 4; d++) begin
            sh = (d > 2) ? 2 : d;
            @(posedge mclk);
            cfg_depth <= d[1:0];
            pm_u.pat_base(d[1:0], 29'h1555_5555);
            @(posedge mclk);
            #1;
            chk(pat_addr, (29'h1555_5555 >> (6 + sh)) << (6 + sh));
            chk({pat_bytes, dst_width_pixels}, {16'h0040 << sh, 13'h1FFF >> sh});
            chk(depth_reserved, d == 3);
        end
        $display("test depth done");
        pm_u.load(3'h0, 32'h0002_0004);
        @(posedge mclk);
        #1;
        chk({extent_active, dst_height}, {1'b1, 13'h0002});
        repeat (2) pm_u.line();
        repeat (2) @(posedge mclk);
        #1;
        chk({extent_active, dst_height}, {1'b0, 13'h0000});
        $display("test extent done");
        pm_u.xlate(39'h12_3456_789A, 1'b0);
        #1;
        chk({tr_out_valid, tr_out_addr}, {2'b10, 39'h12_3456_789A});
        pm_u.xlate(39'h21_0000_0040, 1'b1);
        #1;
        chk({tr_out_valid, tr_out_addr}, {2'b11, 39'h21_0000_0040});
        mm(1'b1, 32'h0002_4000, 32'h0000_00BF);
        pm_u.xlate(39'h00_0000_1000, 1'b1);
        #1;
        chk({tr_out_valid, ru_stalled, tr_ready}, 3'b010);
        pm_u.xlate(39'h00_0000_2000, 1'b0);
        #1;
        chk({tr_out_valid, ru_stalled, tr_ready}, 3'b010);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk({ru_stalled, tr_ready}, 2'b01);
        $display("test translation done");
        stop_test();
    end
endmodule
